// *** host_model.sv ***
// Host controller model driving the inhibit and servo enable pins
// Assumes the bench asks for pin levels; the host changes them just after a clock edge
`timescale 1ns/10ps
module host_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cw_req_i, // Wanted clockwise inhibit level
  input wire logic ccw_req_i, // Wanted counter-clockwise inhibit level
  input wire logic en_req_i, // Wanted servo enable level
  output logic cw_drive_inhibit_o,
  output logic ccw_drive_inhibit_o,
  output logic servo_enable_in_o
);
  // ==========================================
  // Pin drivers
  // Registered so pins move only after an edge, never on the sampling edge itself
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cw_drive_inhibit_o <= 1'b0;
      ccw_drive_inhibit_o <= 1'b0;
      servo_enable_in_o <= 1'b0;
    end
    else
    begin
      cw_drive_inhibit_o <= cw_req_i;
      ccw_drive_inhibit_o <= ccw_req_i;
      servo_enable_in_o <= en_req_i;
    end
  end
endmodule // host_model

// *** pin_sync.sv ***
// Two-flop synchroniser for a vector of pin inputs
// Assumes inputs are asynchronous to clk_i
`timescale 1ns/10ps
module pin_sync #(
  parameter int W = 3
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  // ==========================================
  // Stages
  logic [W-1:0] meta_q; // Read only by the second stage
  // An empty vector has nothing to carry
  if (W < 1)
  begin : g_bad_width
    $error("pin_sync needs a width of at least 1");
  end
  // Both stages clear on reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_q <= '0;
      q_o <= '0;
    end
    else
    begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule // pin_sync

// *** stop_pkg.sv ***
// Shared constants for the stop sequence selector
// Assumes a Wishbone classic slave with 32-bit data and byte addresses
package stop_pkg;
  // ==========================================
  // Register offsets (byte addresses)
  localparam logic [7:0] CTRL_OFS = 8'h00; // Settings and servo enable
  localparam logic [7:0] STAT_OFS = 8'h04; // Live stop state
  localparam logic [7:0] EVT_OFS = 8'h08; // Not decoded; reads zero like any unmapped offset
  // ==========================================
  // Control field positions
  localparam int OT_LSB = 0; // Overtravel setting, 2 bits
  localparam int AL_LSB = 4; // Alarm setting, 2 bits
  localparam int SO_LSB = 8; // Servo-off setting, 3 bits
  localparam int EN_BIT = 12; // Servo enable command
  // ==========================================
  // Reset values
  localparam logic [1:0] OT_RST = 2'h0;
  localparam logic [1:0] AL_RST = 2'h0;
  localparam logic [2:0] SO_RST = 3'h0;
  // Stop sequence phases
  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_OT = 3'b001,
    ST_AL = 3'b010,
    ST_SO = 3'b011
  } stop_state_t;
endpackage

// *** stop_sequence_selector.sv ***
// Stop sequence selector: picks brake, coast or zero clamp on stop events
// Assumes Wishbone classic master on clk_i; pins arrive asynchronously
// Operation
// - Overtravel setting 0-2 on either inhibit
// - Setting 0: drop torque, dynamic brake
// - Setting 1: drop torque, coast freely
// - Setting 2: zero speed clamp deceleration
// - Alarm setting 0-3 on any trip
// - Alarm patterns brake/coast; always clear counter
// - Servo-off setting 0-7 on enable fall while running
// - Settings 4-7 repeat pattern, retain counter
`timescale 1ns/10ps
module stop_sequence_selector (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic cw_drive_inhibit_i,
  input wire logic ccw_drive_inhibit_i,
  input wire logic servo_enable_in_i,
  input wire logic alarm_trip_i,
  input wire logic motor_stopped_i,
  output logic dynamic_brake_o,
  output logic torque_off_o,
  output logic cw_torque_block_o,
  output logic ccw_torque_block_o,
  output logic zero_clamp_o,
  output logic dev_clear_o
);
  // ==========================================
  // Synchronised pins
  logic cw_s, ccw_s, en_s; // Pins after two flops
  pin_sync #(.W(3)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({cw_drive_inhibit_i, ccw_drive_inhibit_i, servo_enable_in_i}),
    .q_o({cw_s, ccw_s, en_s})
  );
  // ==========================================
  // Registers
  logic [1:0] ot_set_q; // Overtravel stop setting
  logic [1:0] al_set_q; // Alarm stop setting
  logic [2:0] so_set_q; // Servo-off stop setting
  logic sw_en_q; // Software servo enable, ANDed with pin
  logic en_q; // Last combined enable, for edge detect
  logic stopped_q; // Motor at standstill, registered
  stop_pkg::stop_state_t state_q; // Active stop sequence
  logic [2:0] seq_set_q; // Setting latched at entry
  logic en_now; // Combined enable level
  assign en_now = en_s & sw_en_q;
  // Brake pattern: bit0 coast in decel, bit1 coast after stop
  function automatic logic brake_sel(input logic [1:0] pat, input logic stopped);
    brake_sel = stopped ? ~pat[1] : ~pat[0];
  endfunction
  // ==========================================
  // Wishbone slave: one-cycle ack, unmapped reads zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h0;
      ot_set_q <= stop_pkg::OT_RST;
      al_set_q <= stop_pkg::AL_RST;
      so_set_q <= stop_pkg::SO_RST;
      sw_en_q <= 1'b0;
    end
    else
    begin
      ack_o <= cyc_i & stb_i & ~ack_o;
      dat_o <= 32'h0;
      if (cyc_i && stb_i && !ack_o)
      begin
        if (we_i && adr_i == stop_pkg::CTRL_OFS)
        begin
          if (sel_i[0])
          begin
            // Out-of-range overtravel values are refused
            if (dat_i[stop_pkg::OT_LSB +: 2] != 2'h3)
              ot_set_q <= dat_i[stop_pkg::OT_LSB +: 2];
            al_set_q <= dat_i[stop_pkg::AL_LSB +: 2];
          end
          if (sel_i[1])
          begin
            so_set_q <= dat_i[stop_pkg::SO_LSB +: 3];
            sw_en_q <= dat_i[stop_pkg::EN_BIT];
          end
        end
        else if (!we_i)
        begin
          case (adr_i)
            stop_pkg::CTRL_OFS: dat_o <= {19'h0, sw_en_q, 1'b0, so_set_q, 2'h0, al_set_q, 2'h0, ot_set_q};
            stop_pkg::STAT_OFS: dat_o <= {24'h0, zero_clamp_o, dev_clear_o, torque_off_o,
                                          dynamic_brake_o, 1'b0, state_q};
            default: dat_o <= 32'h0;
          endcase
        end
      end
    end
  end
  // ==========================================
  // Sequence selection
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q <= stop_pkg::ST_RUN;
      seq_set_q <= 3'h0;
      en_q <= 1'b0;
      stopped_q <= 1'b0;
    end
    else
    begin
      en_q <= en_now;
      stopped_q <= motor_stopped_i;
      if (alarm_trip_i && state_q != stop_pkg::ST_AL)
      begin
        // Alarm preempts any other sequence
        state_q <= stop_pkg::ST_AL;
        seq_set_q <= {1'b0, al_set_q};
      end
      else
      begin
        case (state_q)
          stop_pkg::ST_RUN:
          begin
            if (en_q && !en_now)
            begin
              state_q <= stop_pkg::ST_SO;
              seq_set_q <= so_set_q;
            end
            else if (cw_s || ccw_s)
            begin
              state_q <= stop_pkg::ST_OT;
              seq_set_q <= {1'b0, ot_set_q};
            end
          end
          // Overtravel ends once both inhibits release
          stop_pkg::ST_OT: if (!cw_s && !ccw_s) state_q <= stop_pkg::ST_RUN;
          // Alarm held until trip clears and enable is low
          stop_pkg::ST_AL: if (!alarm_trip_i && !en_now) state_q <= stop_pkg::ST_RUN;
          // Servo-off ends when enable returns
          stop_pkg::ST_SO: if (en_now) state_q <= stop_pkg::ST_RUN;
          default: state_q <= stop_pkg::ST_RUN;
        endcase
      end
    end
  end
  // ==========================================
  // Drive outputs from the latched setting
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dynamic_brake_o <= 1'b0;
      torque_off_o <= 1'b0;
      cw_torque_block_o <= 1'b0;
      ccw_torque_block_o <= 1'b0;
      zero_clamp_o <= 1'b0;
      dev_clear_o <= 1'b0;
    end
    else
    begin
      dynamic_brake_o <= 1'b0;
      torque_off_o <= 1'b0;
      cw_torque_block_o <= 1'b0;
      ccw_torque_block_o <= 1'b0;
      zero_clamp_o <= 1'b0;
      dev_clear_o <= 1'b0;
      case (state_q)
        stop_pkg::ST_OT:
        begin
          // Torque dropped only in the inhibited direction
          cw_torque_block_o <= cw_s & (seq_set_q[1:0] != 2'h2);
          ccw_torque_block_o <= ccw_s & (seq_set_q[1:0] != 2'h2);
          dynamic_brake_o <= (seq_set_q[1:0] == 2'h0);
          zero_clamp_o <= (seq_set_q[1:0] == 2'h2);
        end
        stop_pkg::ST_AL:
        begin
          torque_off_o <= 1'b1;
          dynamic_brake_o <= brake_sel(seq_set_q[1:0], stopped_q);
          dev_clear_o <= 1'b1;
        end
        stop_pkg::ST_SO:
        begin
          torque_off_o <= 1'b1;
          dynamic_brake_o <= brake_sel(seq_set_q[1:0], stopped_q);
          dev_clear_o <= ~seq_set_q[2];
        end
        default: ;
      endcase
    end
  end
  // ==========================================
  // Checks
  property p_alarm_prio;
    @(posedge clk_i) disable iff (rst_i) alarm_trip_i |=> state_q == stop_pkg::ST_AL;
  endproperty
  a_alarm_prio: assert property (p_alarm_prio) else $error("alarm not taken");
  property p_al_clear;
    @(posedge clk_i) disable iff (rst_i) state_q == stop_pkg::ST_AL |=> dev_clear_o;
  endproperty
  a_al_clear: assert property (p_al_clear) else $error("alarm counter not cleared");
  property p_so_entry;
    @(posedge clk_i) disable iff (rst_i)
      (state_q == stop_pkg::ST_RUN && en_q && !en_now && !alarm_trip_i) |=> state_q == stop_pkg::ST_SO;
  endproperty
  a_so_entry: assert property (p_so_entry) else $error("servo-off not entered");
  property p_so_retain;
    @(posedge clk_i) disable iff (rst_i)
      (state_q == stop_pkg::ST_SO && seq_set_q[2]) |=> !dev_clear_o;
  endproperty
  a_so_retain: assert property (p_so_retain) else $error("counter not retained");
  property p_ot_clamp;
    @(posedge clk_i) disable iff (rst_i)
      (state_q == stop_pkg::ST_OT && seq_set_q[1:0] == 2'h2) |=> zero_clamp_o && !dynamic_brake_o;
  endproperty
  a_ot_clamp: assert property (p_ot_clamp) else $error("zero clamp missing");
  property p_ot_brake;
    @(posedge clk_i) disable iff (rst_i)
      (state_q == stop_pkg::ST_OT && seq_set_q[1:0] == 2'h0) |=> dynamic_brake_o;
  endproperty
  a_ot_brake: assert property (p_ot_brake) else $error("overtravel brake missing");
  property p_ot_coast;
    @(posedge clk_i) disable iff (rst_i)
      (state_q == stop_pkg::ST_OT && seq_set_q[1:0] == 2'h1) |=> !dynamic_brake_o && !zero_clamp_o;
  endproperty
  a_ot_coast: assert property (p_ot_coast) else $error("overtravel coast wrong");
  property p_ot_entry;
    @(posedge clk_i) disable iff (rst_i)
      (state_q == stop_pkg::ST_RUN && (cw_s || ccw_s) && !alarm_trip_i && !(en_q && !en_now))
      |=> state_q == stop_pkg::ST_OT;
  endproperty
  a_ot_entry: assert property (p_ot_entry) else $error("overtravel not entered");
  property p_al_set;
    @(posedge clk_i) disable iff (rst_i)
      (alarm_trip_i && state_q != stop_pkg::ST_AL) |=> seq_set_q[1:0] == $past(al_set_q);
  endproperty
  a_al_set: assert property (p_al_set) else $error("alarm setting not latched");
  // Stored overtravel setting never holds the refused code 3
  property p_ot_range;
    @(posedge clk_i) disable iff (rst_i) ot_set_q != 2'h3;
  endproperty
  a_ot_range: assert property (p_ot_range) else $error("overtravel setting out of range");
  // Torque stays on in a direction whose inhibit is released
  property p_ot_dir_cw;
    @(posedge clk_i) disable iff (rst_i)
      (state_q == stop_pkg::ST_OT && !cw_s) |=> !cw_torque_block_o;
  endproperty
  a_ot_dir_cw: assert property (p_ot_dir_cw) else $error("clockwise torque blocked wrongly");
  // Same for the counter-clockwise side
  property p_ot_dir_ccw;
    @(posedge clk_i) disable iff (rst_i)
      (state_q == stop_pkg::ST_OT && !ccw_s) |=> !ccw_torque_block_o;
  endproperty
  a_ot_dir_ccw: assert property (p_ot_dir_ccw) else $error("counter-clockwise torque blocked wrongly");
  // Alarm decel phase: pattern bit 0 picks coast over brake
  property p_al_decel;
    @(posedge clk_i) disable iff (rst_i)
      (state_q == stop_pkg::ST_AL && !stopped_q) |=> dynamic_brake_o == !$past(seq_set_q[0]);
  endproperty
  a_al_decel: assert property (p_al_decel) else $error("alarm decel brake wrong");
  // Alarm after standstill: pattern bit 1 picks coast over brake
  property p_al_stop;
    @(posedge clk_i) disable iff (rst_i)
      (state_q == stop_pkg::ST_AL && stopped_q) |=> dynamic_brake_o == !$past(seq_set_q[1]);
  endproperty
  a_al_stop: assert property (p_al_stop) else $error("alarm standstill brake wrong");
  // Servo-off decel follows the same pattern bit as the alarm
  property p_so_decel;
    @(posedge clk_i) disable iff (rst_i)
      (state_q == stop_pkg::ST_SO && !stopped_q) |=> dynamic_brake_o == !$past(seq_set_q[0]);
  endproperty
  a_so_decel: assert property (p_so_decel) else $error("servo-off decel brake wrong");
  // Low servo-off settings clear the deviation counter
  property p_so_clear;
    @(posedge clk_i) disable iff (rst_i)
      (state_q == stop_pkg::ST_SO && !seq_set_q[2]) |=> dev_clear_o;
  endproperty
  a_so_clear: assert property (p_so_clear) else $error("servo-off counter not cleared");
  // Servo-off always removes torque and never clamps speed
  property p_so_torque;
    @(posedge clk_i) disable iff (rst_i) state_q == stop_pkg::ST_SO |=> torque_off_o && !zero_clamp_o;
  endproperty
  a_so_torque: assert property (p_so_torque) else $error("servo-off torque still on");
  // ==========================================
  // Idle and bus checks
  // Running motor sees neither torque off nor dynamic brake
  property p_run_idle;
    @(posedge clk_i) disable iff (rst_i) state_q == stop_pkg::ST_RUN |=> !torque_off_o && !dynamic_brake_o;
  endproperty
  a_run_idle: assert property (p_run_idle) else $error("stop action while running");
  // Ack is one cycle wide; a request held on is taken again every second cycle
  property p_ack_pulse;
    @(posedge clk_i) disable iff (rst_i) ack_o |=> !ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held over two cycles");
  // Every taken request is answered on the next edge
  property p_ack_answer;
    @(posedge clk_i) disable iff (rst_i) (cyc_i && stb_i && !ack_o) |=> ack_o;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("request not acknowledged");
endmodule // stop_sequence_selector

// *** test_stop_sequence_selector.sv ***
// Self-checking bench for the stop sequence selector
// Assumes one 100 MHz clock and a classic Wishbone master in this bench
`timescale 1ns/10ps
module test_stop_sequence_selector;
  // ==========================================
  // Stimulus and observed signals
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hf; // Byte enables, all lanes unless a test narrows them
  logic [31:0] dat_w = 32'h0, dat_r, q;
  logic ack, alarm = 1'b0, stopped = 1'b0;
  logic cw_req = 1'b0, ccw_req = 1'b0, en_req = 1'b0; // Host model requests
  logic cw_pin, ccw_pin, en_pin;
  logic brk, toff, cwb, ccwb, zc, dc;
  int fail_count = 0, checked = 0;
  wire logic [31:0] outs = {26'h0, toff, zc, dc, ccwb, cwb, brk}; // All sequence outputs in one word
  always #5 clk_i = ~clk_i;
  host_model i_host (.clk_i(clk_i), .rst_i(rst_i), .cw_req_i(cw_req), .ccw_req_i(ccw_req), .en_req_i(en_req),
    .cw_drive_inhibit_o(cw_pin), .ccw_drive_inhibit_o(ccw_pin), .servo_enable_in_o(en_pin));
  stop_sequence_selector i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(dat_w), .dat_o(dat_r), .ack_o(ack), .cw_drive_inhibit_i(cw_pin),
    .ccw_drive_inhibit_i(ccw_pin), .servo_enable_in_i(en_pin), .alarm_trip_i(alarm),
    .motor_stopped_i(stopped), .dynamic_brake_o(brk), .torque_off_o(toff), .cw_torque_block_o(cwb),
    .ccw_torque_block_o(ccwb), .zero_clamp_o(zc), .dev_clear_o(dc));
  // ==========================================
  // Bus, compare and closing tasks
  // One classic cycle; waits for ack, only the watchdog ends a hang
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat_w <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = dat_r;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask
  task automatic stat(input logic [2:0] e);
    wb(1'b0, stop_pkg::STAT_OFS, 32'h0);
    chk("state", {29'h0, e}, {29'h0, q[2:0]});
  endtask
  task automatic settle();
    repeat (8) @(posedge clk_i); // Sync, edge detect and output stages, with margin
  endtask
  function automatic logic [31:0] ctrl(int ot, int al, int so);
    return (32'(ot) << stop_pkg::OT_LSB) | (32'(al) << stop_pkg::AL_LSB) | (32'(so) << stop_pkg::SO_LSB)
      | (32'h1 << stop_pkg::EN_BIT);
  endfunction
  task automatic test_done();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ==========================================
  // Watchdog, far beyond the expected run
  initial
  begin
    #300000;
    fail_count++;
    test_done();
  end
  // ==========================================
  // Test sequence
  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int a = 0; a < 16; a += 4)
    begin
      wb(1'b0, 8'(a) + 8'h30 * 8'(a == 12), 32'h0);
      chk("reset read", 32'h0, q);
    end
    $display("test reset done");
    // Alarm patterns, then servo enable drop must not steal the alarm
    for (int s = 0; s < 4; s++)
    begin
      wb(1'b1, stop_pkg::CTRL_OFS, ctrl(0, s, 0));
      en_req <= 1'b1; settle(); alarm <= 1'b1; settle();
      stat(3'h2);
      chk("alarm decel", {26'h0, 5'b10100, ~s[0]}, outs);
      stopped <= 1'b1; settle();
      chk("alarm stop", {26'h0, 5'b10100, ~s[1]}, outs);
      en_req <= 1'b0; settle();
      stat(3'h2);
      alarm <= 1'b0; stopped <= 1'b0; settle();
    end
    $display("test alarm done");
    // Servo-off patterns with counter cleared or retained
    for (int s = 0; s < 8; s++)
    begin
      wb(1'b1, stop_pkg::CTRL_OFS, ctrl(0, 0, s));
      en_req <= 1'b1; settle();
      stat(3'h0);
      en_req <= 1'b0; settle();
      stat(3'h3);
      chk("servo-off decel", {26'h0, 2'b10, ~s[2], 2'b00, ~s[0]}, outs);
      stopped <= 1'b1; settle();
      chk("servo-off stop", {26'h0, 2'b10, ~s[2], 2'b00, ~s[1]}, outs);
      stopped <= 1'b0; en_req <= 1'b1; settle();
    end
    $display("test servo-off done");
    // Overtravel settings on alternating inhibit pins
    for (int s = 0; s < 3; s++)
    begin
      wb(1'b1, stop_pkg::CTRL_OFS, ctrl(s, 0, 0));
      cw_req <= ~s[0]; ccw_req <= s[0]; settle();
      stat(3'h1);
      chk("overtravel", {26'h0, 1'b0, s == 2, 1'b0, s == 1, s == 0, s == 0}, outs);
      cw_req <= 1'b0; ccw_req <= 1'b0; settle();
      stat(3'h0);
    end
    // Out-of-range overtravel value leaves the field alone
    wb(1'b1, stop_pkg::CTRL_OFS, ctrl(1, 2, 5));
    wb(1'b1, stop_pkg::CTRL_OFS, ctrl(3, 2, 5));
    wb(1'b0, stop_pkg::CTRL_OFS, 32'h0);
    chk("ctrl", ctrl(1, 2, 5), q);
    // Low byte lane only: servo-off field and enable keep their values
    sel <= 4'h1;
    wb(1'b1, stop_pkg::CTRL_OFS, ctrl(2, 3, 7));
    sel <= 4'hf;
    wb(1'b0, stop_pkg::CTRL_OFS, 32'h0);
    chk("ctrl lanes", ctrl(2, 3, 5), q);
    $display("test overtravel done");
    test_done();
  end
endmodule // test_stop_sequence_selector
